/* rtl/sbof_block_len.sv */
// Block length rounding and clamping for the output formatter.
// Assumes a FIFO of 2**FIFO_LOG2 half-word entries, FIFO_LOG2 of at least 3.
`timescale 1ns/1ns
module sbof_block_len
  import sbof_pkg::*;
#(
  parameter int FIFO_LOG2 = 10
) (
  input wire logic [LEN_W-1:0] reqLen,
  input wire logic [1:0] bpsLog2,
  input wire logic append,
  output logic [4:0] effLog2
);
  logic [4:0] minLog2;
  logic [4:0] maxLog2;
  logic [4:0] rounded;

  always_comb begin
    rounded = 5'h00;
    for (int i = 0; i < LEN_W; i++) begin
      if (reqLen[i]) begin
        rounded = 5'(i);
      end
    end
    minLog2 = 5'h03 - {3'h0, bpsLog2};
    // The trailer word must fit beside the data, so appending halves the largest block.
    maxLog2 = 5'(FIFO_LOG2 + 1) - {3'h0, bpsLog2} - {4'h0, append};
    effLog2 = rounded;
    if (rounded < minLog2) begin
      effLog2 = minLog2;
    end
    if (rounded > maxLog2) begin
      effLog2 = maxLog2;
    end
  end
endmodule

/* rtl/sbof_fifo.sv */
// Sample FIFO with an optional wraparound read of one held block.
// Assumes flush is a one-cycle pulse given while no read is in progress.
`timescale 1ns/1ns
module sbof_fifo #(
  parameter int WIDTH = 17,
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic flush,
  input wire logic keep,
  input wire logic wrValid,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic pop,
  output logic full,
  output logic empty,
  output logic [WIDTH-1:0] head,
  output logic [AW:0] used
);
  localparam int DEPTH = 1 << AW;
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW-1:0] next_wrPtr;
  logic [AW-1:0] next_rdPtr;
  logic [AW:0] next_used;
  logic wrEn;
  logic popEn;

  assign full = used == DEPTH_CNT;
  assign empty = used == '0;
  assign head = mem[rdPtr];
  assign wrEn = wrValid && !full;
  assign popEn = pop && !empty;

  always_comb begin
    next_wrPtr = wrPtr + AW'(wrEn);
    next_rdPtr = rdPtr;
    next_used = used + (AW + 1)'(wrEn) - (AW + 1)'(popEn && !keep);
    if (popEn) begin
      next_rdPtr = rdPtr + 1'b1;
      // Held data is never freed, so the read simply returns to the block start.
      if (keep && next_rdPtr == used[AW-1:0]) begin
        next_rdPtr = '0;
      end
    end
    if (flush) begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_used = '0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      used <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      used <= next_used;
    end
  end

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrPtr] <= wrData;
    end
  end

  wrap_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    keep && popEn && !flush && rdPtr + 1'b1 == used[AW-1:0] && !wrEn
    |=> rdPtr == '0 && used == $past(used))
    else $error("held block read did not wrap to its start");
endmodule

/* rtl/sbof_formatter.sv */
// Output formatter: packs samples into the FIFO in blocks and delivers them
// over the register port (backplane path) or the local bus stream.
// Assumes samples, converter flags and lbReady are synchronous to clk.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ns
// Summary of operation
// - With the real-only type each sample puts only its real part into the stream.
// - With the real-imaginary type the real part goes first and the imaginary part right after.
// - Each part is two's complement at half-word or full-word precision as selected.
// - The requested block length is rounded down to a power of two.
// - A sample takes 2, 4, 4 or 8 bytes for real half, real full, complex half, complex full.
// - A length below the minimum of 4, 2, 2 or 1 samples is raised to that minimum.
// - A length whose data would not fit the FIFO is cut to the largest length that fits.
// - Single-block collection stops as soon as one whole block is gathered.
// - Collection until stopped runs on until the FIFO overflows or the idle command comes; wraparound read stops it after one block.
// - With the trailer enabled one status byte follows the last sample of every block.
// - The trailer has bit 0 set for a converter overload and bit 1 for a converter error.
// - On the backplane path the trailer sits in the low 8 bits of a 16-bit word.
// - On the local bus the trailer is flagged as the last byte of the block.
// - All output leaves by exactly one selected path, backplane or local bus.
// - With wraparound read the FIFO holds one block and reads past its end restart it.
module sbof_formatter
  import sbof_pkg::*;
#(
  parameter int FIFO_LOG2 = 10
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [31:0] sampleRe,
  input wire logic [31:0] sampleIm,
  input wire logic adcOverload,
  input wire logic adcError,
  output logic [WORD_W-1:0] lbData,
  output logic lbValid,
  output logic lbLast,
  input wire logic lbReady,
  output logic irq
);
  localparam int CW = FIFO_LOG2 + 1;
  localparam logic [CW-1:0] ONE_WORD = CW'(1);

  sbof_state_t state;
  sbof_state_t next_state;
  logic [CTRL_CFG_W-1:0] ctrl;
  logic [CTRL_CFG_W-1:0] next_ctrl;
  logic [LEN_W-1:0] blkReq;
  logic [LEN_W-1:0] next_blkReq;
  logic [INT_W-1:0] intStat;
  logic [INT_W-1:0] next_intStat;
  logic [INT_W-1:0] intEn;
  logic [INT_W-1:0] next_intEn;
  logic [WORD_W-1:0] q [4];
  logic [WORD_W-1:0] next_q [4];
  logic [2:0] pend;
  logic [2:0] next_pend;
  logic [CW-1:0] wordsLeft;
  logic [CW-1:0] next_wordsLeft;
  logic [CW-1:0] blkWords;
  logic [CW-1:0] next_blkWords;
  logic blkOvl;
  logic next_blkOvl;
  logic blkErr;
  logic next_blkErr;
  logic overflow;
  logic next_overflow;
  logic [31:0] next_regRdata;
  logic next_sampleReady;
  logic [WORD_W-1:0] next_lbData;
  logic next_lbValid;
  logic next_lbLast;
  logic next_irq;

  logic [4:0] effLog2;
  logic [1:0] bpsLog2;
  logic [CW-1:0] blkWordsNew;
  logic [2:0] sampleWords;
  logic startCmd;
  logic idleCmd;
  logic take;
  logic stopAfterBlock;
  logic evDone;
  logic evOvf;
  logic fifoWrValid;
  logic [ENTRY_W-1:0] fifoWrData;
  logic fifoFull;
  logic fifoEmpty;
  logic [ENTRY_W-1:0] fifoHead;
  logic [CW-1:0] fifoUsed;
  logic bpPop;
  logic lbPop;
  logic pathLocal;
  logic writeWord;

  // Format bits steer the packer live; software changes them only while idle.
  assign pathLocal = ctrl[CTRL_LOCAL_BUS];
  assign bpsLog2 = 2'h1 + {1'b0, ctrl[CTRL_REAL_IMAG]} + {1'b0, ctrl[CTRL_FULL_WORD]};
  assign sampleWords = 3'h1 << (bpsLog2 - 2'h1);
  assign blkWordsNew = ONE_WORD << (effLog2 + {3'h0, bpsLog2} - 5'h01);
  assign startCmd = regWr && regAddr == REG_CTRL && regWdata[CTRL_START];
  assign idleCmd = regWr && regAddr == REG_CTRL && regWdata[CTRL_IDLE];
  assign take = sampleValid && sampleReady;
  // Wraparound read keeps a single block, so it ends collection like block mode.
  assign stopAfterBlock = !ctrl[CTRL_UNTIL_STOPPED] || ctrl[CTRL_WRAPAROUND];
  assign writeWord = (state == ST_COLLECT && pend != 3'h0) || state == ST_TRAILER;
  assign fifoWrValid = writeWord && !startCmd;
  assign bpPop = regRd && regAddr == REG_DATA && !pathLocal;
  assign lbPop = pathLocal && !fifoEmpty && (!lbValid || lbReady);

  always_comb begin
    fifoWrData = {1'b0, q[0]};
    if (state == ST_TRAILER) begin
      fifoWrData = '0;
      fifoWrData[TRL_OVERLOAD] = blkOvl;
      fifoWrData[TRL_ERROR] = blkErr;
      fifoWrData[ENTRY_LAST] = 1'b1;
    end else if (!ctrl[CTRL_TRAILER] && wordsLeft == ONE_WORD) begin
      fifoWrData[ENTRY_LAST] = 1'b1;
    end
  end

  sbof_block_len #(
    .FIFO_LOG2(FIFO_LOG2)
  ) u_sbof_block_len (
    .reqLen(blkReq),
    .bpsLog2(bpsLog2),
    .append(ctrl[CTRL_TRAILER]),
    .effLog2(effLog2)
  );

  sbof_fifo #(
    .WIDTH(ENTRY_W),
    .AW(FIFO_LOG2)
  ) u_sbof_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .flush(startCmd),
    .keep(ctrl[CTRL_WRAPAROUND]),
    .wrValid(fifoWrValid),
    .wrData(fifoWrData),
    .pop(bpPop || lbPop),
    .full(fifoFull),
    .empty(fifoEmpty),
    .head(fifoHead),
    .used(fifoUsed)
  );

  always_comb begin
    next_state = state;
    next_q = q;
    next_pend = pend;
    next_wordsLeft = wordsLeft;
    next_blkWords = blkWords;
    next_blkOvl = blkOvl || adcOverload;
    next_blkErr = blkErr || adcError;
    next_overflow = overflow;
    evDone = 1'b0;
    evOvf = 1'b0;
    if (take) begin
      next_q[0] = sampleRe[31:16];
      next_q[1] = sampleRe[15:0];
      next_q[2] = sampleIm[31:16];
      next_q[3] = sampleIm[15:0];
      if (!ctrl[CTRL_FULL_WORD]) begin
        next_q[1] = sampleIm[31:16];
      end
      next_pend = sampleWords;
    end
    case (state)
      ST_COLLECT: begin
        if (pend != 3'h0 && !fifoFull) begin
          next_q[0] = q[1];
          next_q[1] = q[2];
          next_q[2] = q[3];
          next_pend = pend - 3'h1;
          next_wordsLeft = wordsLeft - ONE_WORD;
          if (wordsLeft == ONE_WORD) begin
            if (ctrl[CTRL_TRAILER]) begin
              next_state = ST_TRAILER;
            end else begin
              evDone = 1'b1;
              next_blkOvl = adcOverload;
              next_blkErr = adcError;
              next_wordsLeft = blkWords;
              next_state = stopAfterBlock ? ST_DONE : ST_COLLECT;
            end
          end
        end else if (pend != 3'h0 && ctrl[CTRL_UNTIL_STOPPED]) begin
          evOvf = 1'b1;
          next_overflow = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_TRAILER: begin
        if (!fifoFull) begin
          evDone = 1'b1;
          next_blkOvl = adcOverload;
          next_blkErr = adcError;
          next_wordsLeft = blkWords;
          next_state = stopAfterBlock ? ST_DONE : ST_COLLECT;
        end else if (ctrl[CTRL_UNTIL_STOPPED]) begin
          evOvf = 1'b1;
          next_overflow = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_IDLE, ST_DONE: begin
        next_pend = 3'h0;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (startCmd) begin
      next_state = ST_COLLECT;
      next_pend = 3'h0;
      next_blkWords = blkWordsNew;
      next_wordsLeft = blkWordsNew;
      next_overflow = 1'b0;
      next_blkOvl = adcOverload;
      next_blkErr = adcError;
    end else if (idleCmd) begin
      next_state = ST_IDLE;
      next_pend = 3'h0;
    end
    next_sampleReady = next_state == ST_COLLECT && next_pend == 3'h0;
  end

  always_comb begin
    next_ctrl = ctrl;
    next_blkReq = blkReq;
    next_intEn = intEn;
    next_intStat = intStat;
    next_regRdata = 32'h0000_0000;
    if (regWr && regAddr == REG_CTRL) begin
      next_ctrl = regWdata[CTRL_CFG_W-1:0];
    end
    if (regWr && regAddr == REG_BLK_REQ) begin
      next_blkReq = regWdata[LEN_W-1:0];
    end
    if (regWr && regAddr == REG_INT_EN) begin
      next_intEn = regWdata[INT_W-1:0];
    end
    if (regWr && regAddr == REG_INT_CLR) begin
      next_intStat = intStat & ~regWdata[INT_W-1:0];
    end
    // Events are merged after the clear so a same-cycle event is kept.
    next_intStat[INT_BLOCK_DONE] = next_intStat[INT_BLOCK_DONE] || evDone;
    next_intStat[INT_OVERFLOW] = next_intStat[INT_OVERFLOW] || evOvf;
    next_intStat[INT_ADC_FAULT] = next_intStat[INT_ADC_FAULT] ||
      (state != ST_IDLE && (adcOverload || adcError));
    next_irq = |(next_intStat & next_intEn);
    if (regRd) begin
      case (regAddr)
        REG_CTRL: next_regRdata = {26'h0, ctrl};
        REG_BLK_REQ: next_regRdata = {8'h00, blkReq};
        REG_BLK_LEN: next_regRdata = 32'h1 << effLog2;
        REG_STATUS: begin
          next_regRdata[STAT_COLLECTING] = state == ST_COLLECT || state == ST_TRAILER;
          next_regRdata[STAT_OVERFLOW] = overflow;
          next_regRdata[STAT_DONE] = state == ST_DONE;
          next_regRdata[STAT_COUNT_LSB +: CW] = fifoUsed;
        end
        REG_DATA: begin
          if (bpPop && !fifoEmpty) begin
            next_regRdata = {15'h0000, fifoHead};
          end
        end
        REG_INT_STAT: next_regRdata = {29'h0, intStat};
        REG_INT_EN: next_regRdata = {29'h0, intEn};
        default: next_regRdata = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    next_lbData = lbData;
    next_lbLast = lbLast;
    next_lbValid = lbValid && !lbReady;
    if (lbPop) begin
      next_lbData = fifoHead[WORD_W-1:0];
      next_lbLast = fifoHead[ENTRY_LAST];
      next_lbValid = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      ctrl <= CTRL_RESET;
      blkReq <= BLK_REQ_RESET;
      intStat <= INT_RESET;
      intEn <= INT_RESET;
      q <= '{default: '0};
      pend <= 3'h0;
      wordsLeft <= '0;
      blkWords <= '0;
      blkOvl <= 1'b0;
      blkErr <= 1'b0;
      overflow <= 1'b0;
      regRdata <= 32'h0000_0000;
      sampleReady <= 1'b0;
      lbData <= '0;
      lbValid <= 1'b0;
      lbLast <= 1'b0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      blkReq <= next_blkReq;
      intStat <= next_intStat;
      intEn <= next_intEn;
      q <= next_q;
      pend <= next_pend;
      wordsLeft <= next_wordsLeft;
      blkWords <= next_blkWords;
      blkOvl <= next_blkOvl;
      blkErr <= next_blkErr;
      overflow <= next_overflow;
      regRdata <= next_regRdata;
      sampleReady <= next_sampleReady;
      lbData <= next_lbData;
      lbValid <= next_lbValid;
      lbLast <= next_lbLast;
      irq <= next_irq;
    end
  end

  sequence lastDataWritten;
    state == ST_COLLECT && pend != 3'h0 && !fifoFull && wordsLeft == ONE_WORD;
  endsequence

  sequence trailerWritten;
    state == ST_TRAILER && !fifoFull && !startCmd;
  endsequence

  real_only_a: assert property (@(posedge clk) disable iff (!arst_n)
    take && !ctrl[CTRL_REAL_IMAG] && !ctrl[CTRL_FULL_WORD] && !startCmd && !idleCmd
    |=> q[0] == $past(sampleRe[31:16]) && pend == 3'h1)
    else $error("real-only sample not packed as one real word");

  imag_follows_a: assert property (@(posedge clk) disable iff (!arst_n)
    take && ctrl[CTRL_REAL_IMAG] && !ctrl[CTRL_FULL_WORD] && !startCmd && !idleCmd
    |=> q[0] == $past(sampleRe[31:16]) && q[1] == $past(sampleIm[31:16]))
    else $error("imaginary part does not follow the real part");

  sample_words_a: assert property (@(posedge clk) disable iff (!arst_n)
    take && !startCmd && !idleCmd |=> pend == $past(sampleWords))
    else $error("sample does not occupy its size in words");

  block_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    startCmd |=> (blkWords & (blkWords - ONE_WORD)) == '0 &&
      blkWords <= (ONE_WORD << FIFO_LOG2) && blkWords >= CW'(2))
    else $error("block length not a power of two within limits");

  trailer_after_a: assert property (@(posedge clk) disable iff (!arst_n)
    lastDataWritten and (ctrl[CTRL_TRAILER] && !startCmd && !idleCmd)
    |=> state == ST_TRAILER ##1 (state != ST_TRAILER || fifoFull))
    else $error("trailer word did not follow the last sample");

  trailer_flags_a: assert property (@(posedge clk) disable iff (!arst_n)
    trailerWritten |-> fifoWrData[TRL_OVERLOAD] == blkOvl &&
      fifoWrData[TRL_ERROR] == blkErr && fifoWrData[ENTRY_LAST])
    else $error("trailer flags wrong");

  block_stop_a: assert property (@(posedge clk) disable iff (!arst_n)
    evDone && stopAfterBlock && !startCmd && !idleCmd
    |=> state == ST_DONE && !sampleReady)
    else $error("single-block collection did not stop");

  keep_going_a: assert property (@(posedge clk) disable iff (!arst_n)
    evDone && !stopAfterBlock && !startCmd && !idleCmd
    |=> state == ST_COLLECT && wordsLeft == blkWords)
    else $error("continuous collection stopped after a block");

  overflow_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    evOvf && !startCmd |=> overflow && state == ST_IDLE ##1 (overflow || $past(startCmd)))
    else $error("overflow flag not raised or not held");

  one_path_a: assert property (@(posedge clk) disable iff (!arst_n)
    pathLocal && $stable(ctrl) |=> !(regRdata != 32'h0 && $past(regAddr) == REG_DATA))
    else $error("backplane data delivered while the local bus is selected");

  irq_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 irq == |(intStat & intEn))
    else $error("interrupt output does not follow enabled status");
endmodule

/* rtl/sbof_pkg.sv */
// Constants shared by the sample block output formatter.
// Assumes one clock domain and a register port with byte addresses on word bounds.
package sbof_pkg;
  localparam int ADDR_W = 8;
  localparam int LEN_W = 24;
  localparam int WORD_W = 16;
  localparam int ENTRY_W = 17;
  localparam int ENTRY_LAST = 16;

  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_BLK_REQ = 8'h04;
  localparam logic [ADDR_W-1:0] REG_BLK_LEN = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_DATA = 8'h10;
  localparam logic [ADDR_W-1:0] REG_INT_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] REG_INT_EN = 8'h18;
  localparam logic [ADDR_W-1:0] REG_INT_CLR = 8'h1c;

  localparam int CTRL_REAL_IMAG = 0;
  localparam int CTRL_FULL_WORD = 1;
  localparam int CTRL_UNTIL_STOPPED = 2;
  localparam int CTRL_TRAILER = 3;
  localparam int CTRL_LOCAL_BUS = 4;
  localparam int CTRL_WRAPAROUND = 5;
  localparam int CTRL_CFG_W = 6;
  localparam int CTRL_START = 8;
  localparam int CTRL_IDLE = 9;
  localparam logic [CTRL_CFG_W-1:0] CTRL_RESET = 6'h00;
  localparam logic [LEN_W-1:0] BLK_REQ_RESET = 24'h000400;

  localparam int STAT_COLLECTING = 0;
  localparam int STAT_OVERFLOW = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_COUNT_LSB = 16;

  localparam int INT_W = 3;
  localparam int INT_BLOCK_DONE = 0;
  localparam int INT_OVERFLOW = 1;
  localparam int INT_ADC_FAULT = 2;
  localparam logic [INT_W-1:0] INT_RESET = 3'h0;

  localparam int TRL_OVERLOAD = 0;
  localparam int TRL_ERROR = 1;

  typedef enum {ST_IDLE, ST_COLLECT, ST_TRAILER, ST_DONE} sbof_state_t;
endpackage

/* tb/sbof_host_model.sv */
// Host-side model: a sample source and a local bus sink.
// Assumes it shares clk and arst_n with the formatter under test.
`timescale 1ns/1ns
module sbof_host_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic srcEn,
  input wire logic slowSink,
  input wire logic sampleReady,
  output logic sampleValid,
  output logic [31:0] sampleRe,
  output logic [31:0] sampleIm,
  input wire logic [15:0] lbData,
  input wire logic lbValid,
  input wire logic lbLast,
  output logic lbReady
);
  int k;
  int kn;
  logic [16:0] got[$];
  function automatic logic [31:0] reOf(input int n);
    return {16'h8000 | 16'(n), 16'h1000 | 16'(n)};
  endfunction
  function automatic logic [31:0] imOf(input int n);
    return {16'h4000 | 16'(n), 16'h2000 | 16'(n)};
  endfunction
  assign kn = srcEn ? k + int'(sampleValid && sampleReady) : 0;
  // Idle data lines toggle so a stale sample can never pass for a fresh one.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      k <= 0;
      sampleValid <= 1'h0;
      sampleRe <= 32'h0;
      sampleIm <= 32'h0;
      lbReady <= 1'h0;
    end else begin
      k <= kn;
      sampleValid <= srcEn;
      sampleRe <= srcEn ? reOf(kn) : ~sampleRe;
      sampleIm <= srcEn ? imOf(kn) : ~sampleIm;
      lbReady <= slowSink ? !lbReady : 1'h1;
      if (lbValid && lbReady) begin
        got.push_back({lbLast, lbData});
      end
    end
  end
endmodule

/* tb/test_sbof_formatter.sv */
// Self-checking bench for the sample block output formatter.
// Assumes sbof_host_model feeds samples and sinks the local bus.
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin \
  totalChecks++; \
  if ((gt) !== (ex)) begin \
    fails++; \
    $display("Error %s expected %h seen %h", nm, (ex), (gt)); \
  end \
end
module test_sbof_formatter
  import sbof_pkg::*;
;
  localparam int FL = 4;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic [ADDR_W-1:0] regAddr = 8'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic adcOverload = 1'h0;
  logic adcError = 1'h0;
  logic srcEn = 1'h0;
  logic slowSink = 1'h0;
  logic [31:0] regRdata, sampleRe, sampleIm, d;
  logic sampleValid, sampleReady, lbValid, lbLast, lbReady, irq;
  logic [15:0] lbData;
  int fails = 0;
  int totalChecks = 0;
  int cycles = 0;
  int reqTab[3] = '{0, 5, 24'hffffff};

  sbof_formatter #(.FIFO_LOG2(FL)) u_sbof_formatter (.clk(clk), .arst_n(arst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .sampleRe(sampleRe), .sampleIm(sampleIm), .adcOverload(adcOverload),
    .adcError(adcError), .lbData(lbData), .lbValid(lbValid), .lbLast(lbLast),
    .lbReady(lbReady), .irq(irq));
  sbof_host_model u_sbof_host_model (.clk(clk), .arst_n(arst_n), .srcEn(srcEn),
    .slowSink(slowSink), .sampleReady(sampleReady), .sampleValid(sampleValid),
    .sampleRe(sampleRe), .sampleIm(sampleIm), .lbData(lbData), .lbValid(lbValid),
    .lbLast(lbLast), .lbReady(lbReady));

  always #2 clk = ~clk;

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The whole run needs several hundred cycles; this only cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      giveVerdict();
    end
  end

  task automatic wrReg(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rdReg(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    #1;
    v = regRdata;
    @(posedge clk);
  endtask

  task automatic waitStat(input int b);
    for (int i = 0; i < 60; i++) begin
      rdReg(REG_STATUS, d);
      if (d[b] === 1'h1) break;
    end
    `CHK("status bit", 1'h1, d[b]);
  endtask

  function automatic int expLen(input int bps, input int app, input int req);
    int lg;
    lg = -1;
    for (int b = 0; b < LEN_W; b++) if (req[b]) lg = b;
    if (lg < 3 - bps) lg = 3 - bps;
    if (lg > FL + 1 - bps - app) lg = FL + 1 - bps - app;
    return 1 << lg;
  endfunction

  task automatic runBlock(input logic [5:0] cfg, input int req, input logic ovl,
                          input logic err);
    int n;
    int rdN;
    logic [31:0] re;
    logic [31:0] im;
    logic [16:0] q[$];
    n = expLen(1 + cfg[CTRL_REAL_IMAG] + cfg[CTRL_FULL_WORD], cfg[CTRL_TRAILER], req);
    for (int s = 0; s < n; s++) begin
      re = u_sbof_host_model.reOf(s);
      im = u_sbof_host_model.imOf(s);
      q.push_back({1'h0, re[31:16]});
      if (cfg[CTRL_FULL_WORD]) q.push_back({1'h0, re[15:0]});
      if (cfg[CTRL_REAL_IMAG]) q.push_back({1'h0, im[31:16]});
      if (cfg[CTRL_REAL_IMAG] && cfg[CTRL_FULL_WORD]) q.push_back({1'h0, im[15:0]});
    end
    if (cfg[CTRL_TRAILER]) q.push_back({1'h1, 14'h0, err, ovl});
    else q[q.size()-1][16] = 1'h1;
    srcEn <= 1'h0;
    u_sbof_host_model.got.delete();
    wrReg(REG_CTRL, 32'h200);
    wrReg(REG_CTRL, 32'(cfg));
    wrReg(REG_BLK_REQ, 32'(req));
    rdReg(REG_BLK_LEN, d);
    `CHK("block length", 32'(n), d);
    wrReg(REG_CTRL, 32'(cfg) | 32'h100);
    srcEn <= 1'h1;
    adcOverload <= ovl;
    adcError <= err;
    @(posedge clk);
    adcOverload <= 1'h0;
    adcError <= 1'h0;
    waitStat(STAT_DONE);
    srcEn <= 1'h0;
    rdN = q.size() + (cfg[CTRL_WRAPAROUND] ? 2 : 0);
    if (cfg[CTRL_LOCAL_BUS]) begin
      rdReg(REG_DATA, d);
      `CHK("data on local path", 32'h0, d);
      for (int i = 0; i < 200 && u_sbof_host_model.got.size() < q.size(); i++) @(posedge clk);
      `CHK("local count", q.size(), u_sbof_host_model.got.size());
      foreach (q[i]) `CHK("local word", q[i], u_sbof_host_model.got[i]);
    end else begin
      rdReg(REG_STATUS, d);
      `CHK("words held", 11'(q.size()), d[26:16]);
      for (int i = 0; i < rdN; i++) begin
        rdReg(REG_DATA, d);
        `CHK("data word", {15'h0, q[i % q.size()]}, d);
      end
      rdReg(REG_DATA, d);
      `CHK("after end", cfg[CTRL_WRAPAROUND] ? {15'h0, q[2]} : 32'h0, d);
    end
    rdReg(REG_INT_STAT, d);
    `CHK("event flags", {29'h0, ovl | err, 2'h1}, d);
    `CHK("irq level", 1'h1, irq);
    wrReg(REG_INT_CLR, 32'h7);
    rdReg(REG_INT_STAT, d);
    `CHK("flags cleared", 32'h0, d);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    rdReg(REG_CTRL, d);
    `CHK("control reset", 32'(CTRL_RESET), d);
    rdReg(REG_BLK_REQ, d);
    `CHK("request reset", 32'(BLK_REQ_RESET), d);
    rdReg(8'h20, d);
    `CHK("unmapped read", 32'h0, d);
    for (int t = 0; t < 8; t++) begin
      for (int r = 0; r < 3; r++) begin
        wrReg(REG_CTRL, 32'((t & 3) | ((t & 4) << 1)));
        wrReg(REG_BLK_REQ, 32'(reqTab[r]));
        rdReg(REG_BLK_LEN, d);
        `CHK("length table", 32'(expLen(1 + t[0] + t[1], t[2], reqTab[r])), d);
      end
    end
    wrReg(REG_INT_EN, 32'h7);
    runBlock(6'h08, 4, 1'h1, 1'h0);
    runBlock(6'h02, 5, 1'h0, 1'h0);
    runBlock(6'h01, 8, 1'h0, 1'h0);
    slowSink <= 1'h1;
    runBlock(6'h1b, 2, 1'h0, 1'h1);
    runBlock(6'h20, 4, 1'h0, 1'h0);
    wrReg(REG_CTRL, 32'h4);
    wrReg(REG_CTRL, 32'h104);
    srcEn <= 1'h1;
    waitStat(STAT_OVERFLOW);
    srcEn <= 1'h0;
    `CHK("stopped on overflow", 2'h2, d[1:0]);
    `CHK("full count", 11'(1 << FL), d[26:16]);
    wrReg(REG_INT_EN, 32'h0);
    `CHK("irq masked", 1'h0, irq);
    wrReg(REG_INT_EN, 32'h7);
    `CHK("irq raised", 1'h1, irq);
    wrReg(REG_INT_CLR, 32'h7);
    wrReg(REG_CTRL, 32'h104);
    rdReg(REG_STATUS, d);
    `CHK("restart", 2'h1, d[1:0]);
    wrReg(REG_CTRL, 32'h204);
    rdReg(REG_STATUS, d);
    `CHK("idle command", 2'h0, d[1:0]);
    giveVerdict();
  end
endmodule
